// ==== core/scps_pkg.sv ====
/*
 Constants for the configuration pin sequencer: mode strap encoding, stream
 framing, CRC polynomial, timing counts. Assumes a single 10 MHz clock domain.
*/
package scps_pkg;

   // Strap encoding {bit2,bit1,bit0}
   localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;
   localparam logic [2:0] MODE_SLAVE_PAR     = 3'h3;
   localparam logic [2:0] MODE_MASTER_PAR    = 3'h4;
   localparam logic [2:0] MODE_PERIPH        = 3'h5;
   localparam logic [2:0] MODE_SLAVE_SERIAL  = 3'h7;

   // Stream framing: preamble byte, 32-bit length, payload, CRC-16 (MSB first)
   localparam logic [7:0]  PREAMBLE  = 8'hA5;
   localparam logic [15:0] CRC_POLY  = 16'h1021;
   localparam logic [15:0] CRC_INIT  = 16'hFFFF;
   localparam int          LEN_BYTES = 4;
   localparam int          CRC_BYTES = 2;

   // Timing
   localparam int CLK_HZ          = 10_000_000;
   localparam int MCLK_HALF_NS    = 500;
   localparam int MCLK_HALF_CYC   = (MCLK_HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int INIT_NS         = 2_000;
   localparam int INIT_CYC        = (INIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

   typedef enum logic [2:0] {
      ST_INIT, ST_PRE, ST_LEN, ST_DATA, ST_CRC, ST_ERR, ST_WAIT_DONE, ST_USER
   } scps_state_t;

endpackage : scps_pkg

// ==== core/scps_shift.sv ====
/*
 Bit/byte assembler with running CRC-16 over completed bytes.
 Assumes strobes are single-cycle pulses in the clk domain.
*/
`timescale 1ns/1ps
module scps_shift
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       clear,
   // Input strobes
   input  wire logic       bit_stb,
   input  wire logic       bit_in,
   input  wire logic       byte_stb,
   input  wire logic [7:0] byte_in,
   // Result
   output logic            byte_vld_q,
   output logic [7:0]      byte_q,
   output logic [15:0]     crc_q
);
   logic [2:0]  cnt_q;
   logic [7:0]  sh_q;
   logic [7:0]  sh_d;
   logic        full;
   logic [7:0]  new_byte;

   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--)
      begin
         if (r[15] ^ b[i])
            r = {r[14:0], 1'b0} ^ scps_pkg::CRC_POLY;
         else
            r = {r[14:0], 1'b0};
      end
      return r;
   endfunction : crc_byte

   assign sh_d     = {sh_q[6:0], bit_in};
   assign full     = bit_stb && (cnt_q == 3'h7);
   assign new_byte = byte_stb ? byte_in : sh_d;

   always_ff @(posedge clk)
   begin
      if (!reset_n || clear)
      begin
         cnt_q      <= 3'h0;
         sh_q       <= 8'h00;
         byte_vld_q <= 1'b0;
         byte_q     <= 8'h00;
         crc_q      <= scps_pkg::CRC_INIT;
      end
      else
      begin
         byte_vld_q <= byte_stb || full;
         if (bit_stb)
         begin
            sh_q  <= sh_d;
            cnt_q <= cnt_q + 3'h1;
         end
         if (byte_stb || full)
         begin
            byte_q <= new_byte;
            crc_q  <= crc_byte(crc_q, new_byte);
         end
      end
   end
endmodule : scps_shift

// ==== core/scps_loader.sv ====
/*
 Configuration pin sequencer: strap decode, strobe handling, stream check,
 status pins and hand-over to user I/O. Assumes all pins are asynchronous
 to clk and are passed through two flip-flops before use.
*/
`timescale 1ns/1ps
module scps_loader
#(
   parameter int ADDR_W = 20
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Control pins
   input  wire logic              global_reset_n,
   input  wire logic              prog_restart_n,
   input  wire logic              global_tristate,
   // Mode straps
   input  wire logic              mode_strap_bit0,
   input  wire logic              mode_strap_bit1,
   input  wire logic              mode_strap_bit2,
   input  wire logic              mode_strap_high,
   // Peripheral selects
   input  wire logic              chip_select_low_n,
   input  wire logic              chip_select_high,
   // Configuration strobe
   input  wire logic              cfg_strobe_i,
   output logic                   cfg_strobe_o,
   output logic                   cfg_strobe_oe,
   // Data
   input  wire logic              serial_in,
   input  wire logic [7:0]        par_data,
   output logic                   serial_out,
   output logic [ADDR_W-1:0]      mem_addr,
   output logic                   mem_addr_oe,
   // Completion pin
   input  wire logic              done_i,
   output logic                   done_o,
   output logic                   done_oe,
   // Check error pin
   output logic                   check_err_o,
   output logic                   check_err_oe,
   output logic                   check_err_pullup,
   // Status
   output logic                   cfg_active_high,
   output logic                   cfg_active_n,
   // User I/O control
   output logic                   user_io_en,
   output logic                   io_pulldown_en,
   output logic                   user_ff_clear_n,
   output logic                   scan_reset
);
   // Two-flop synchronisers, bits: grst,prst,gts,m0,m1,m2,m3,csl,csh,strb,sin,done
   localparam int NS = 12;
   logic [NS-1:0] s1_q, s2_q, raw;
   logic [7:0]    d1_q, d2_q;
   assign raw = {done_i, serial_in, cfg_strobe_i, chip_select_high, chip_select_low_n,
                 mode_strap_high, mode_strap_bit2, mode_strap_bit1, mode_strap_bit0,
                 global_tristate, prog_restart_n, global_reset_n};
   always_ff @(posedge clk)
   begin
      s1_q <= raw;
      s2_q <= s1_q;
      d1_q <= par_data;
      d2_q <= d1_q;
   end

   wire       grst_n  = s2_q[0];
   wire       prst_n  = s2_q[1];
   wire       gts     = s2_q[2];
   wire [2:0] mode    = s2_q[5:3];
   wire       sel     = !s2_q[7] && s2_q[8];
   wire       strb_s  = s2_q[9];
   wire       sin_s   = s2_q[10];
   wire       done_s  = s2_q[11];

   // Mode decode
   wire m_master  = (mode == scps_pkg::MODE_MASTER_SERIAL) ||
                    (mode == scps_pkg::MODE_MASTER_PAR);
   wire m_par     = (mode == scps_pkg::MODE_MASTER_PAR) || (mode == scps_pkg::MODE_SLAVE_PAR)
                    || (mode == scps_pkg::MODE_PERIPH);
   wire m_periph  = (mode == scps_pkg::MODE_PERIPH);

   scps_pkg::scps_state_t st_q, st_d;
   logic        strb_q, mclk_q, mstrb_prev_q;
   logic [3:0]  div_q;
   logic [7:0]  ic_q;
   logic [31:0] len_q, cnt_q;
   logic [ADDR_W-1:0] addr_q;
   logic        err_q, sout_q, sout_next_q;
   logic [7:0]  byte_q;
   logic        bvld;
   logic [15:0] crc;
   logic        clr;

   // Strobe edges: own divider in master modes, sampled pin otherwise
   wire in_cfg   = (st_q == scps_pkg::ST_PRE) || (st_q == scps_pkg::ST_LEN) ||
                   (st_q == scps_pkg::ST_DATA) || (st_q == scps_pkg::ST_CRC);
   wire div_hit  = (div_q == 4'(scps_pkg::MCLK_HALF_CYC - 1));
   wire strb_cur = m_master ? mclk_q : strb_s;
   wire rise     = strb_cur && !strb_q && in_cfg && (!m_periph || sel);
   wire fall     = !strb_cur && strb_q && in_cfg;
   wire bit_stb  = rise && !m_par;
   wire byte_stb = rise && m_par;
   wire [7:0] pbyte = {d2_q[7:1], sin_s};

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         div_q  <= 4'h0;
         mclk_q <= 1'b0;
         strb_q <= 1'b0;
      end
      else
      begin
         strb_q <= strb_cur;
         div_q  <= (div_hit || !in_cfg || !m_master) ? 4'h0 : div_q + 4'h1;
         if (!in_cfg || !m_master)
            mclk_q <= 1'b0;
         else if (div_hit)
            mclk_q <= !mclk_q;
      end
   end

   scps_shift u_shift
   (
      .clk        (clk),
      .reset_n    (reset_n),
      .clear      (clr),
      .bit_stb    (bit_stb),
      .bit_in     (sin_s),
      .byte_stb   (byte_stb),
      .byte_in    (pbyte),
      .byte_vld_q (bvld),
      .byte_q     (byte_q),
      .crc_q      (crc)
   );

   // Sequencer
   wire restart  = !prst_n;
   wire crc_ok   = (crc == 16'h0000);
   wire last_len = (cnt_q == 32'(scps_pkg::LEN_BYTES - 1));
   wire last_dat = (cnt_q + 32'h1 >= len_q);
   wire last_crc = (cnt_q == 32'(scps_pkg::CRC_BYTES - 1));
   assign clr    = (st_q == scps_pkg::ST_INIT) || (bvld && st_q == scps_pkg::ST_PRE &&
                   byte_q == scps_pkg::PREAMBLE);

   always_comb
   begin
      st_d = st_q;
      case (st_q)
         scps_pkg::ST_INIT:
            if (ic_q == 8'(scps_pkg::INIT_CYC) && prst_n && grst_n)
               st_d = scps_pkg::ST_PRE;
         scps_pkg::ST_PRE:
            if (bvld)
               st_d = (byte_q == scps_pkg::PREAMBLE) ? scps_pkg::ST_LEN
                                                     : scps_pkg::ST_ERR;
         scps_pkg::ST_LEN:
            if (bvld && last_len)
               st_d = scps_pkg::ST_DATA;
         scps_pkg::ST_DATA:
            if (bvld && last_dat)
               st_d = scps_pkg::ST_CRC;
         scps_pkg::ST_CRC:
            if (bvld && last_crc)
               st_d = crc_ok ? scps_pkg::ST_WAIT_DONE : scps_pkg::ST_ERR;
         scps_pkg::ST_ERR:
            if (prst_n && grst_n)
               st_d = scps_pkg::ST_INIT;
         scps_pkg::ST_WAIT_DONE:
            if (done_s)
               st_d = scps_pkg::ST_USER;
         scps_pkg::ST_USER:
            st_d = scps_pkg::ST_USER;
         default:
            st_d = scps_pkg::ST_INIT;
      endcase
      if (restart)
         st_d = scps_pkg::ST_INIT;
      else if (!grst_n && in_cfg)
         st_d = scps_pkg::ST_INIT;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         st_q   <= scps_pkg::ST_INIT;
         ic_q   <= 8'h00;
         cnt_q  <= 32'h0;
         len_q  <= 32'h0;
         addr_q <= '0;
         err_q  <= 1'b0;
      end
      else
      begin
         st_q  <= st_d;
         ic_q  <= (st_q == scps_pkg::ST_INIT && ic_q != 8'(scps_pkg::INIT_CYC)) ?
                  ic_q + 8'h1 : (st_q == scps_pkg::ST_INIT ? ic_q : 8'h00);
         if (st_d == scps_pkg::ST_ERR)
            err_q <= 1'b1;
         else if (st_d == scps_pkg::ST_PRE)
            err_q <= 1'b0;
         if (st_q != st_d)
            cnt_q <= 32'h0;
         else if (bvld)
            cnt_q <= cnt_q + 32'h1;
         if (bvld && st_q == scps_pkg::ST_LEN)
            len_q <= {len_q[23:0], byte_q};
         if (st_q == scps_pkg::ST_INIT)
            addr_q <= '0;
         else if (byte_stb && mode == scps_pkg::MODE_MASTER_PAR)
            addr_q <= addr_q + ADDR_W'(1);
      end
   end

   // Daisy-chain output, changed on strobe falling edge
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         sout_next_q <= 1'b1;
         sout_q      <= 1'b1;
         mstrb_prev_q <= 1'b0;
      end
      else
      begin
         mstrb_prev_q <= rise;
         if (rise)
            sout_next_q <= sin_s;
         if (fall)
            sout_q <= sout_next_q;
      end
   end

   // Registered pin outputs
   wire cfg_phase = (st_q != scps_pkg::ST_USER);
   wire done_rel  = (st_q == scps_pkg::ST_WAIT_DONE) || (st_q == scps_pkg::ST_USER);
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         cfg_strobe_o     <= 1'b0;
         cfg_strobe_oe    <= 1'b0;
         serial_out       <= 1'b1;
         mem_addr         <= '0;
         mem_addr_oe      <= 1'b0;
         done_o           <= 1'b0;
         done_oe          <= 1'b1;
         check_err_o      <= 1'b0;
         check_err_oe     <= 1'b0;
         check_err_pullup <= 1'b1;
         cfg_active_high  <= 1'b1;
         cfg_active_n     <= 1'b0;
         user_io_en       <= 1'b0;
         io_pulldown_en   <= 1'b0;
         user_ff_clear_n  <= 1'b0;
         scan_reset       <= 1'b1;
      end
      else
      begin
         cfg_strobe_o     <= mclk_q;
         cfg_strobe_oe    <= cfg_phase && m_master;
         serial_out       <= sout_q;
         mem_addr         <= addr_q;
         mem_addr_oe      <= cfg_phase && (mode == scps_pkg::MODE_MASTER_PAR) && !gts;
         done_o           <= 1'b0;
         done_oe          <= !done_rel;
         check_err_o      <= 1'b0;
         check_err_oe     <= err_q;
         check_err_pullup <= cfg_phase;
         cfg_active_high  <= cfg_phase;
         cfg_active_n     <= !cfg_phase;
         user_io_en       <= (st_q == scps_pkg::ST_USER) && !gts;
         io_pulldown_en   <= gts;
         user_ff_clear_n  <= (st_q == scps_pkg::ST_USER) && grst_n;
         scan_reset       <= restart;
      end
   end
endmodule : scps_loader

// ==== bench/scps_checker.sv ====
/* Port checker for scps_loader.
   Assumes the board holds its pins steady for several cycles. */
`timescale 1ns/1ps
module scps_checker
#(
   parameter int ADDR_W = 20
)
(
   // Clock and reset
   input wire logic              clk,
   input wire logic              reset_n,
   // Pins in
   input wire logic              global_reset_n,
   input wire logic              prog_restart_n,
   input wire logic              global_tristate,
   input wire logic              mode_strap_bit0,
   input wire logic              mode_strap_bit1,
   input wire logic              done_i,
   // Pins out
   input wire logic              cfg_strobe_oe,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic              mem_addr_oe,
   input wire logic              done_oe,
   input wire logic              check_err_oe,
   input wire logic              check_err_pullup,
   input wire logic              cfg_active_high,
   input wire logic              user_io_en,
   input wire logic              io_pulldown_en,
   input wire logic              user_ff_clear_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   strobe_master_a: assert property (
      cfg_strobe_oe |-> $past(!mode_strap_bit0 && !mode_strap_bit1, 3))
      else $error("strobe driven outside master mode");
   addr_step_a: assert property (
      mem_addr_oe && $changed(mem_addr) && mem_addr != '0 |-> mem_addr == $past(mem_addr) + 1'b1)
      else $error("memory address skipped");
   done_rel_a: assert property (!cfg_active_high |-> !done_oe)
      else $error("completion held low after configuration");
   io_hold_a: assert property ($rose(user_io_en) |-> !done_oe && $past(done_i))
      else $error("user I/O enabled while completion low");
   err_hold_a: assert property (
      check_err_oe && !(global_reset_n && prog_restart_n) |=> check_err_oe)
      else $error("error released while restart or reset low");
   err_clear_a: assert property (
      $fell(check_err_oe) |-> check_err_pullup && $past(global_reset_n, 3) && $past(prog_restart_n, 3))
      else $error("error released too early");
   tri_pd_a: assert property (global_tristate [*5] |-> io_pulldown_en)
      else $error("pull-downs off while tri-state high");
   ff_clear_a: assert property (
      (!global_reset_n && !cfg_active_high) [*4] |-> !user_ff_clear_n)
      else $error("user flops not cleared by reset");
endmodule : scps_checker

bind scps_loader scps_checker #(.ADDR_W(ADDR_W)) i_scps_checker (.clk, .reset_n,
   .global_reset_n, .prog_restart_n, .global_tristate, .mode_strap_bit0, .mode_strap_bit1,
   .done_i, .cfg_strobe_oe, .mem_addr, .mem_addr_oe, .done_oe, .check_err_oe,
   .check_err_pullup, .cfg_active_high, .user_io_en, .io_pulldown_en, .user_ff_clear_n);

// ==== bench/scps_src_model.sv ====
/* Source model: strobes bytes serially or bytewise, serves a fixed memory byte.
   Assumes one request at a time, held until acknowledged. */
`timescale 1ns/1ps
module scps_src_model
(
   // Clock
   input  wire logic       clk,
   // Bench request
   input  wire logic       go,
   input  wire logic [7:0] byte_val,
   input  wire logic       par_mode,
   output logic            ack,
   // Memory select
   input  wire logic       mem_addr_oe,
   // Pins
   output logic            cfg_strobe_i,
   output logic            serial_in,
   output logic [7:0]      par_data
);
   logic [5:0] cnt_q = 6'h00;
   logic       busy_q = 1'b0;
   logic       idle_q = 1'b0;
   logic       ack_q = 1'b0;
   wire  [5:0] last_w = par_mode ? 6'h07 : 6'h3f;
   wire  [2:0] bit_w = 3'h7 - cnt_q[5:3];
   wire        end_w = busy_q && cnt_q == last_w;

   assign ack = ack_q;
   // Strobe still between bytes, data set half a period before each rise
   assign cfg_strobe_i = busy_q & cnt_q[2];
   assign serial_in = mem_addr_oe ? 1'b0 : !busy_q ? idle_q :
                      par_mode ? byte_val[0] : byte_val[bit_w];
   assign par_data = mem_addr_oe ? 8'h5a : busy_q ? byte_val : {8{idle_q}};
   always @(posedge clk)
   begin
      idle_q <= ~idle_q;
      ack_q <= end_w;
      cnt_q <= busy_q ? cnt_q + 6'h01 : 6'h00;
      if (end_w)
         busy_q <= 1'b0;
      else if (go && !ack_q)
         busy_q <= 1'b1;
   end
endmodule : scps_src_model

// ==== bench/scps_loader_tb.sv ====
/* Bench for scps_loader: master, peripheral and serial loads, errors, hand-over.
   Assumes the source model on the pins and a pulled-up completion line. */
`timescale 1ns/1ps
module scps_loader_tb;
   logic clk = 1'b0, reset_n = 1'b0, global_reset_n = 1'b1, prog_restart_n = 1'b1;
   logic global_tristate = 1'b0, cs_low_n = 1'b1, cs_high = 1'b0, hold_done = 1'b0;
   logic go = 1'b0, par_mode = 1'b0;
   logic [7:0] byte_val = 8'h00;
   logic [2:0] mode = scps_pkg::MODE_MASTER_PAR;
   logic [31:0] rng = 32'hadb3_389a;
   logic [4:0] last_q, notes[$];
   logic [7:0] s[9];
   logic [15:0] crc;
   int num_errors = 0, check_count = 0;
   wire logic ack, strobe, sdi, done_i, done_oe, check_err_oe, user_io_en, cfg_active_high;
   wire logic cfg_active_n, cfg_strobe_oe, mem_addr_oe, io_pulldown_en, user_ff_clear_n;
   wire logic check_err_pullup, scan_reset;
   wire logic [7:0] pdata;
   wire logic [4:0] st = {check_err_oe, done_oe, user_io_en, cfg_active_high, cfg_active_n};

   assign done_i = !done_oe && !hold_done;
   always #50 clk = ~clk;

   scps_loader i_scps_loader (.clk, .reset_n, .global_reset_n, .prog_restart_n,
      .global_tristate, .mode_strap_bit0(mode[0]), .mode_strap_bit1(mode[1]),
      .mode_strap_bit2(mode[2]), .mode_strap_high(1'b1),
      .chip_select_low_n(cs_low_n), .chip_select_high(cs_high), .cfg_strobe_i(strobe),
      .cfg_strobe_o(), .cfg_strobe_oe, .serial_in(sdi), .par_data(pdata), .serial_out(),
      .mem_addr(), .mem_addr_oe, .done_i, .done_o(), .done_oe, .check_err_o(),
      .check_err_oe, .check_err_pullup, .cfg_active_high, .cfg_active_n, .user_io_en,
      .io_pulldown_en, .user_ff_clear_n, .scan_reset);
   scps_src_model i_scps_src_model (.clk, .go, .byte_val, .par_mode, .ack, .mem_addr_oe,
      .cfg_strobe_i(strobe), .serial_in(sdi), .par_data(pdata));

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? scps_pkg::CRC_POLY : 16'h0000);
      return c;
   endfunction : crc_step

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic complete_run;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   task automatic drain(input int n);
      repeat (n)
         if (notes.size() != 0)
            @(posedge clk);
      chk(8'(notes.size()), 8'h00);
      notes.delete();
   endtask : drain

   task automatic send(input logic [7:0] b, input logic p);
      @(posedge clk);
      go <= 1'b1;
      byte_val <= b;
      par_mode <= p;
      for (int n = 0; n < 200 && ack !== 1'b1; n++)
         @(posedge clk);
      chk(8'(ack), 8'h01);
      go <= 1'b0;
   endtask : send

   task automatic recover(input logic [2:0] m, input logic by_rst);
      for (int n = 0; n < 400 && check_err_oe !== 1'b1; n++)
         @(posedge clk);
      if (by_rst)
         global_reset_n <= 1'b0;
      else
         prog_restart_n <= 1'b0;
      repeat (40) @(posedge clk);
      if (!by_rst)
         chk(8'(scan_reset), 8'h01);
      mode <= m;
      notes.push_back(5'h0a);
      repeat (10) @(posedge clk);
      global_reset_n <= 1'b1;
      prog_restart_n <= 1'b1;
      drain(100);
   endtask : recover

   // Each change of the status pins consumes the oldest note
   always @(posedge clk)
      if (!reset_n)
         last_q <= 5'h0a;
      else if (st !== last_q)
      begin
         chk(8'(st), 8'(notes.size() != 0 ? notes.pop_front() : last_q));
         last_q <= st;
      end

   initial
   begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      notes.push_back(5'h1a);
      for (int n = 0; n < 300 && cfg_strobe_oe !== 1'b1; n++)
         @(posedge clk);
      chk(8'(cfg_strobe_oe), 8'h01);
      chk(8'(mem_addr_oe), 8'h01);
      recover(scps_pkg::MODE_PERIPH, 1'b0);
      send(8'h5a, 1'b1);
      repeat (20) @(posedge clk);
      cs_low_n <= 1'b0;
      cs_high <= 1'b1;
      notes.push_back(5'h1a);
      send(8'h5a, 1'b1);
      recover(scps_pkg::MODE_SLAVE_SERIAL, 1'b0);
      notes.push_back(5'h1a);
      send(8'h5a, 1'b0);
      recover(scps_pkg::MODE_SLAVE_SERIAL, 1'b1);
      s = '{scps_pkg::PREAMBLE, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
      rng = xs(rng);
      s[5] = rng[7:0];
      rng = xs(rng);
      s[6] = rng[7:0];
      crc = scps_pkg::CRC_INIT;
      for (int i = 1; i < 7; i++)
         crc = crc_step(crc, s[i]);
      s[7] = crc[15:8];
      s[8] = crc[7:0];
      hold_done <= 1'b1;
      notes.push_back(5'h02);
      for (int i = 0; i < 9; i++)
         send(s[i], 1'b0);
      drain(100);
      repeat (50) @(posedge clk);
      notes.push_back(5'h05);
      hold_done <= 1'b0;
      drain(50);
      repeat (4) @(posedge clk);
      chk(8'(user_ff_clear_n), 8'h01);
      chk(8'(check_err_pullup), 8'h00);
      chk(8'(scan_reset), 8'h00);
      notes.push_back(5'h01);
      notes.push_back(5'h05);
      global_tristate <= 1'b1;
      repeat (6) @(posedge clk);
      chk(8'(io_pulldown_en), 8'h01);
      global_tristate <= 1'b0;
      global_reset_n <= 1'b0;
      repeat (4) @(posedge clk);
      chk(8'(user_ff_clear_n), 8'h00);
      global_reset_n <= 1'b1;
      repeat (6) @(posedge clk);
      chk(8'(notes.size()), 8'h00);
      complete_run();
   end

   initial
   begin
      #2_000_000;
      num_errors++;
      complete_run();
   end
endmodule : scps_loader_tb
